/* hw/break_unit.sv */
// Purpose: Bus-cycle break unit comparing CPU and DMA cycles to conditions
// Assumes: One 10 MHz clock, synchronous inputs, plain register port
// Notes: Break request is a level to the interrupt controller until acknowledged
// Functional notes
// - Condition register clears on reset and hardware standby, kept otherwise
// - Upper condition byte reserved, reads zero
// - Source field: none, CPU, DMA, either
// - Kind field: none, fetch, data, both
// - Direction field: none, read, write, both
// - Size field: any, byte, word, longword
// - Fetches always count as word size
// - Size from access, not bus width
// - Any 00 source, kind or direction field blocks every break
// - Full match raises break request
// - Second packed instruction breaks independently
// - Fetch break saves matching fetch address
// - Deferred fetch break saves next address
// - Data break saves next-executed address
// - Compare address held as two halves
// - Mask bit one excludes address bit
`timescale 1ns/1ps
module break_unit #(
  parameter int DATA_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic HW_STANDBY,
  input wire logic [break_unit_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  input wire break_unit_pkg::bus_cycle_s BUS_CYCLE,
  input wire break_unit_pkg::cpu_ctx_s CPU_CTX,
  input wire logic BREAK_ACK,
  output logic BREAK_REQ,
  output logic [3:0] BREAK_LEVEL_OUT,
  output logic [31:0] SAVED_PC,
  output logic IRQ
);

  logic [15:0] addr_hi_r;
  logic [15:0] addr_lo_r;
  logic [15:0] mask_hi_r;
  logic [15:0] mask_lo_r;
  logic [15:0] cond_r;
  logic [1:0] status_r;
  logic [1:0] irq_mask_r;
  logic [DATA_W-1:0] rdata_r;
  logic req_r;
  logic [31:0] pc_r;
  logic irq_r;
  logic [3:0] level_r;

  // Field selection test shared by source, kind and direction
  function automatic logic sel_hit(input logic [1:0] sel, input logic is_second);
    sel_hit = is_second ? sel[1] : sel[0];
  endfunction

  // Register decode
  wire wr_addr_hi = REG_WR && (REG_ADDR == break_unit_pkg::OFS_ADDR_HI);
  wire wr_addr_lo = REG_WR && (REG_ADDR == break_unit_pkg::OFS_ADDR_LO);
  wire wr_mask_hi = REG_WR && (REG_ADDR == break_unit_pkg::OFS_MASK_HI);
  wire wr_mask_lo = REG_WR && (REG_ADDR == break_unit_pkg::OFS_MASK_LO);
  wire wr_cond = REG_WR && (REG_ADDR == break_unit_pkg::OFS_COND);
  wire wr_status = REG_WR && (REG_ADDR == break_unit_pkg::OFS_STATUS);
  wire wr_irq_mask = REG_WR && (REG_ADDR == break_unit_pkg::OFS_IRQ_MASK);

  // Condition fields
  wire [1:0] src_sel = cond_r[break_unit_pkg::SRC_POS +: 2];
  wire [1:0] kind_sel = cond_r[break_unit_pkg::KIND_POS +: 2];
  wire [1:0] dir_sel = cond_r[break_unit_pkg::DIR_POS +: 2];
  wire [1:0] size_sel = cond_r[break_unit_pkg::SIZE_POS +: 2];

  // Compare address and mask as 32-bit words
  wire [31:0] cmp_addr = {addr_hi_r, addr_lo_r};
  wire [31:0] cmp_mask = {mask_hi_r, mask_lo_r};

  // Each bit either excluded by mask or equal to stored bit
  wire [31:0] bit_ok = cmp_mask | ~(BUS_CYCLE.addr ^ cmp_addr);
  wire addr_hit_first = &bit_ok;
  // The second packed instruction sits two bytes above the fetch address
  wire [31:0] second_addr = BUS_CYCLE.addr + 32'h0000_0002;
  wire [31:0] bit_ok2 = cmp_mask | ~(second_addr ^ cmp_addr);
  wire addr_hit_second = BUS_CYCLE.is_fetch && BUS_CYCLE.two_instr && (&bit_ok2);

  wire src_hit = sel_hit(src_sel, BUS_CYCLE.from_dma);
  wire kind_hit = sel_hit(kind_sel, !BUS_CYCLE.is_fetch);
  wire dir_hit = sel_hit(dir_sel, BUS_CYCLE.is_write);
  // Fetches are word size whatever the bus width; data uses its own size
  wire [1:0] eff_size = BUS_CYCLE.is_fetch ? break_unit_pkg::SIZE_WORD : BUS_CYCLE.size;
  wire size_hit = (size_sel == break_unit_pkg::SEL_NONE) || (size_sel == eff_size);
  // A 00 code in any of the three groups fails its own hit term
  wire fields_on = (src_sel != break_unit_pkg::SEL_NONE) && (kind_sel != break_unit_pkg::SEL_NONE)
                   && (dir_sel != break_unit_pkg::SEL_NONE);
  wire cycle_hit = BUS_CYCLE.valid && fields_on && src_hit && kind_hit && dir_hit && size_hit;
  wire match = cycle_hit && (addr_hit_first || addr_hit_second);

  // Saved program counter selection
  wire [31:0] fetch_pc = addr_hit_first ? BUS_CYCLE.addr : second_addr;
  wire [31:0] pc_nxt = !BUS_CYCLE.is_fetch ? CPU_CTX.last_next_pc :
                       CPU_CTX.defer ? CPU_CTX.next_pc :
                       fetch_pc;

  // Read mux; unmapped index answers zero
  logic [15:0] rd_mux;
  always_comb begin
    unique case (REG_ADDR)
      break_unit_pkg::OFS_ADDR_HI: rd_mux = addr_hi_r;
      break_unit_pkg::OFS_ADDR_LO: rd_mux = addr_lo_r;
      break_unit_pkg::OFS_MASK_HI: rd_mux = mask_hi_r;
      break_unit_pkg::OFS_MASK_LO: rd_mux = mask_lo_r;
      break_unit_pkg::OFS_COND: rd_mux = cond_r & break_unit_pkg::COND_WR_MASK;
      break_unit_pkg::OFS_STATUS: rd_mux = {14'h0000, status_r};
      break_unit_pkg::OFS_IRQ_MASK: rd_mux = {14'h0000, irq_mask_r};
      break_unit_pkg::OFS_SAVED_PC: rd_mux = pc_r[15:0];
      default: rd_mux = 16'h0000;
    endcase
  end

  // Sticky events: bit0 break matched, bit1 request acknowledged; set beats clear
  wire [1:0] events = {req_r && BREAK_ACK, match};
  wire [1:0] status_nxt = (status_r & ~(wr_status ? REG_WDATA[1:0] : 2'h0)) | events;

  // Address and mask registers; standby acts like reset but software standby does not
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      addr_hi_r <= 16'h0000;
      addr_lo_r <= 16'h0000;
      mask_hi_r <= 16'h0000;
      mask_lo_r <= 16'h0000;
    end else if (HW_STANDBY) begin
      addr_hi_r <= 16'h0000;
      addr_lo_r <= 16'h0000;
      mask_hi_r <= 16'h0000;
      mask_lo_r <= 16'h0000;
    end else begin
      if (wr_addr_hi) addr_hi_r <= REG_WDATA[15:0];
      if (wr_addr_lo) addr_lo_r <= REG_WDATA[15:0];
      if (wr_mask_hi) mask_hi_r <= REG_WDATA[15:0];
      if (wr_mask_lo) mask_lo_r <= REG_WDATA[15:0];
    end
  end

  // Condition register; reserved byte never stored
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cond_r <= break_unit_pkg::COND_RESET;
    end else if (HW_STANDBY) begin
      cond_r <= break_unit_pkg::COND_RESET;
    end else if (wr_cond) begin
      cond_r <= REG_WDATA[15:0] & break_unit_pkg::COND_WR_MASK;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      status_r <= 2'h0;
      irq_mask_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      // Standby clears status and mask together so no stale interrupt survives it
      status_r <= HW_STANDBY ? 2'h0 : status_nxt;
      if (HW_STANDBY) irq_mask_r <= 2'h0;
      else if (wr_irq_mask) irq_mask_r <= REG_WDATA[1:0];
      irq_r <= HW_STANDBY ? 1'b0 : |(status_nxt & irq_mask_r);
    end
  end

  // Break request held until the controller takes it; pending while refused
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      req_r <= 1'b0;
      pc_r <= 32'h0000_0000;
    end else if (HW_STANDBY) begin
      req_r <= 1'b0;
    end else if (match && !req_r) begin
      req_r <= 1'b1;
      pc_r <= pc_nxt;
    end else if (req_r && BREAK_ACK) begin
      req_r <= 1'b0;
    end
  end

  // Level is fixed, but registered so the port comes straight from a flip-flop
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) level_r <= break_unit_pkg::BREAK_LEVEL;
    else level_r <= break_unit_pkg::BREAK_LEVEL;
  end

  // Read data appears the cycle after the strobe only
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) rdata_r <= '0;
    else rdata_r <= REG_RD ? DATA_W'(rd_mux) : '0;
  end

  assign REG_RDATA = rdata_r;
  assign BREAK_REQ = req_r;
  assign BREAK_LEVEL_OUT = level_r;
  assign SAVED_PC = pc_r;
  assign IRQ = irq_r;

  // Checks
  chk_zero_field_block: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!fields_on) |-> !match) else $error("break matched with a disabled field");
  chk_reserved_reads_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
    (REG_RD && REG_ADDR == break_unit_pkg::OFS_COND) |=> (REG_RDATA[15:8] == 8'h00))
    else $error("reserved condition bits read nonzero");
  chk_match_raises_req: assert property (@(posedge SYS_CLK) disable iff (RST)
    (match && !req_r && !HW_STANDBY) |=> BREAK_REQ) else $error("match did not raise request");
  sequence req_pending_s;
    req_r && !BREAK_ACK && !HW_STANDBY;
  endsequence
  chk_req_held: assert property (@(posedge SYS_CLK) disable iff (RST)
    req_pending_s |=> BREAK_REQ) else $error("pending request dropped");
  chk_fetch_pc: assert property (@(posedge SYS_CLK) disable iff (RST)
    (match && !req_r && !HW_STANDBY && BUS_CYCLE.is_fetch && !CPU_CTX.defer && addr_hit_first)
    |=> (SAVED_PC == $past(BUS_CYCLE.addr))) else $error("fetch break saved wrong pc");
  chk_defer_pc: assert property (@(posedge SYS_CLK) disable iff (RST)
    (match && !req_r && !HW_STANDBY && BUS_CYCLE.is_fetch && CPU_CTX.defer)
    |=> (SAVED_PC == $past(CPU_CTX.next_pc))) else $error("deferred break saved wrong pc");
  chk_data_pc: assert property (@(posedge SYS_CLK) disable iff (RST)
    (match && !req_r && !HW_STANDBY && !BUS_CYCLE.is_fetch)
    |=> (SAVED_PC == $past(CPU_CTX.last_next_pc))) else $error("data break saved wrong pc");
  chk_fetch_word: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && BUS_CYCLE.is_fetch && size_sel == break_unit_pkg::SIZE_WORD) |-> size_hit)
    else $error("fetch not taken as word size");
  chk_mask_excludes: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cmp_mask == 32'hFFFF_FFFF && cycle_hit) |-> match) else $error("full mask failed to match");
  chk_standby_clears: assert property (@(posedge SYS_CLK) disable iff (RST)
    HW_STANDBY |=> (cond_r == break_unit_pkg::COND_RESET)) else $error("standby kept condition");

  // Further checks on the port, the condition fields and the request
  // A new break is one that finds no request already pending
  sequence first_match_s;
    match && !req_r && !HW_STANDBY;
  endsequence
  // The controller taking a pending request
  sequence req_taken_s;
    req_r && BREAK_ACK && !HW_STANDBY;
  endsequence

  // Idle port shows zero, so a late sample cannot pick up stale data
  chk_rdata_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!REG_RD) |=> (REG_RDATA == '0)) else $error("read data without a read");

  // Condition reads return what is stored
  chk_rdata_cond: assert property (@(posedge SYS_CLK) disable iff (RST)
    (REG_RD && REG_ADDR == break_unit_pkg::OFS_COND) |=> (REG_RDATA == $past(cond_r)))
    else $error("condition read returned wrong value");

  // Writes keep only the low byte of the condition register
  chk_cond_write: assert property (@(posedge SYS_CLK) disable iff (RST)
    (wr_cond && !HW_STANDBY) |=> (cond_r == ($past(REG_WDATA[15:0]) & break_unit_pkg::COND_WR_MASK)))
    else $error("condition write stored wrong value");

  // Reserved byte never holds a one
  chk_cond_upper: assert property (@(posedge SYS_CLK) disable iff (RST)
    (cond_r[15:8] == 8'h00)) else $error("reserved condition bits set");

  // Without a write or standby the conditions stay put
  chk_cond_holds: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!wr_cond && !HW_STANDBY) |=> $stable(cond_r)) else $error("condition changed by itself");

  // Source code 01 never breaks on a DMA cycle
  chk_src_cpu_only: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && src_sel == 2'h1 && BUS_CYCLE.from_dma) |-> !match) else $error("CPU source hit DMA");

  // Source code 10 never breaks on a CPU cycle
  chk_src_dma_only: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && src_sel == 2'h2 && !BUS_CYCLE.from_dma) |-> !match) else $error("DMA source hit CPU");

  // Kind code 01 never breaks on a data access
  chk_kind_fetch: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && kind_sel == 2'h1 && !BUS_CYCLE.is_fetch) |-> !match) else $error("fetch kind hit data");

  // Kind code 10 never breaks on a fetch
  chk_kind_data: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && kind_sel == 2'h2 && BUS_CYCLE.is_fetch) |-> !match) else $error("data kind hit fetch");

  // Direction code 01 never breaks on a write
  chk_dir_read: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && dir_sel == 2'h1 && BUS_CYCLE.is_write) |-> !match) else $error("read code hit write");

  // Direction code 10 never breaks on a read
  chk_dir_write: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && dir_sel == 2'h2 && !BUS_CYCLE.is_write) |-> !match) else $error("write code hit read");

  // Data size comes from the access; the bus width plays no part
  chk_size_data: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && !BUS_CYCLE.is_fetch && size_sel != 2'h0 && size_sel != BUS_CYCLE.size) |-> !match)
    else $error("data break with wrong size");

  // Unmasked address bits must all agree on a single-instruction match
  chk_addr_bits: assert property (@(posedge SYS_CLK) disable iff (RST)
    (match && !BUS_CYCLE.two_instr) |-> (((BUS_CYCLE.addr ^ cmp_addr) & ~cmp_mask) == 32'h0000_0000))
    else $error("match with a differing unmasked bit");

  // Only a fetch can carry a second instruction
  chk_second_fetch: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BUS_CYCLE.valid && !BUS_CYCLE.is_fetch && !addr_hit_first) |-> !match) else $error("data hit second slot");

  // A break on the second instruction saves its own start address
  chk_second_pc: assert property (@(posedge SYS_CLK) disable iff (RST)
    first_match_s ##0 (BUS_CYCLE.is_fetch && !CPU_CTX.defer && !addr_hit_first)
    |=> (SAVED_PC == $past(BUS_CYCLE.addr) + 32'h0000_0002)) else $error("second slot saved wrong pc");

  // Every match outside hardware standby is recorded in the status
  chk_status_sets: assert property (@(posedge SYS_CLK) disable iff (RST)
    (match && !HW_STANDBY) |=> status_r[0]) else $error("match not recorded");

  // An enabled match shows on the interrupt line one edge later
  chk_irq_follows: assert property (@(posedge SYS_CLK) disable iff (RST)
    (match && irq_mask_r[0] && !HW_STANDBY) |=> IRQ) else $error("enabled match gave no interrupt");

  // Acceptance lowers the request and is recorded
  chk_ack_clears: assert property (@(posedge SYS_CLK) disable iff (RST)
    req_taken_s |=> !BREAK_REQ) else $error("request stayed after acceptance");
  chk_status_acked: assert property (@(posedge SYS_CLK) disable iff (RST)
    req_taken_s |=> status_r[1]) else $error("acceptance not recorded");

  // The level to the controller never moves
  chk_level_fixed: assert property (@(posedge SYS_CLK) disable iff (RST)
    (BREAK_LEVEL_OUT == break_unit_pkg::BREAK_LEVEL)) else $error("break level changed");

  // Later matches must not overwrite the saved pc of a pending break
  chk_pc_stable: assert property (@(posedge SYS_CLK) disable iff (RST)
    (req_r && !HW_STANDBY) |=> $stable(SAVED_PC)) else $error("saved pc moved while pending");

  // Standby drops request, status and interrupt
  chk_standby_drops: assert property (@(posedge SYS_CLK) disable iff (RST)
    HW_STANDBY |=> (!BREAK_REQ && status_r == 2'h0 && !IRQ)) else $error("standby left break state");

endmodule // break_unit

/* hw/break_unit_pkg.sv */
// Purpose: Shared constants and types for the bus-cycle break unit
// Assumes: 16-bit registers on a plain strobe port
// Notes: Offsets are register indices on the local port
package break_unit_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_ADDR_HI = 3'h0;
  localparam logic [2:0] OFS_ADDR_LO = 3'h1;
  localparam logic [2:0] OFS_MASK_HI = 3'h2;
  localparam logic [2:0] OFS_MASK_LO = 3'h3;
  localparam logic [2:0] OFS_COND = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h6;
  localparam logic [2:0] OFS_SAVED_PC = 3'h7;
  localparam logic [15:0] COND_RESET = 16'h0000;
  localparam logic [15:0] COND_WR_MASK = 16'h00FF;
  localparam int SRC_POS = 6;
  localparam int KIND_POS = 4;
  localparam int DIR_POS = 2;
  localparam int SIZE_POS = 0;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;
  localparam logic [3:0] BREAK_LEVEL = 4'hF;
  // Observed bus cycle
  typedef struct packed {
    logic valid;
    logic from_dma;
    logic is_fetch;
    logic is_write;
    logic [1:0] size;
    logic [31:0] addr;
    logic two_instr;
  } bus_cycle_s;
  // Program-flow context of the CPU when a break is taken
  typedef struct packed {
    logic defer;
    logic [31:0] next_pc;
    logic [31:0] last_next_pc;
  } cpu_ctx_s;
endpackage

/* dv/interrupt_controller_unit_model.sv */
// Purpose: Interrupt controller stand-in that accepts the break request
// Assumes: Request is a level held until acknowledged
// Notes: Acceptance delay comes from the bench, so answers are prompt or slow
`timescale 1ns/1ps
module interrupt_controller_unit_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [3:0] req_level,
  input wire logic [3:0] mask_level,
  input wire logic [3:0] delay,
  output logic ack
);
  logic [3:0] wait_r;
  // Accept only above the mask level; otherwise the request stays pending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'h0;
      wait_r <= 4'h0;
    end else begin
      ack <= 1'h0;
      if (req && !ack && req_level > mask_level) begin
        if (wait_r == delay) begin
          ack <= 1'h1;
          wait_r <= 4'h0;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end else begin
        wait_r <= 4'h0;
      end
    end
  end
endmodule // interrupt_controller_unit_model

/* dv/tb_break_unit.sv */
// Purpose: Self-checking bench for the bus-cycle break unit
// Assumes: Register port reads answer one cycle after the strobe
// Notes: Masked address bits are filled from the bench pseudo-random source
`timescale 1ns/1ps
module tb_break_unit;
  localparam logic [31:0] CMP = 32'h0012_3456;
  localparam logic [31:0] MSK = 32'h0000_00F0;
  localparam logic [31:0] NPC = 32'h0000_1000;
  localparam logic [31:0] LPC = 32'h0000_2000;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic hw_standby = 1'h0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic rd_d = 1'h0;
  logic [15:0] reg_rdata;
  break_unit_pkg::bus_cycle_s bus_cycle = '0;
  break_unit_pkg::cpu_ctx_s cpu_ctx = '0;
  logic ack;
  logic req;
  logic irq;
  logic [3:0] lvl;
  logic [3:0] mask_level = 4'hF;
  logic [3:0] delay = 4'h0;
  logic [31:0] saved_pc;
  logic [15:0] seed = 16'h0007;
  logic [15:0] exp_q[$];
  int miscompares = 0;
  int cmp_count = 0;
  // Clock at 10 MHz
  always #50 sys_clk = ~sys_clk;
  break_unit i_dut (.SYS_CLK(sys_clk), .RST(rst), .HW_STANDBY(hw_standby), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .BUS_CYCLE(bus_cycle),
    .CPU_CTX(cpu_ctx), .BREAK_ACK(ack), .BREAK_REQ(req), .BREAK_LEVEL_OUT(lvl), .SAVED_PC(saved_pc), .IRQ(irq));
  interrupt_controller_unit_model i_interrupt_controller_unit (.clk(sys_clk), .rst(rst), .req(req), .req_level(lvl), .mask_level(mask_level),
    .delay(delay), .ack(ack));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe; match the oldest note
  always @(posedge sys_clk) begin
    if (rd_d) begin
      chk("REG_RDATA", {16'h0000, reg_rdata}, exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end
  // One bus cycle; k is {dma, fetch, write}, f is {two_instr, defer, hit expected}
  task automatic try(input logic [15:0] cond, input logic [2:0] k, input logic [1:0] sz,
                     input logic [31:0] flip, input logic [2:0] f);
    logic [31:0] a;
    logic [31:0] pc;
    seed = lfsr(seed);
    a = CMP ^ flip ^ ({16'h0000, seed} & MSK);
    pc = !k[1] ? LPC : f[1] ? NPC : a + (f[2] ? 32'h2 : 32'h0);
    wr(break_unit_pkg::OFS_COND, cond);
    @(posedge sys_clk);
    bus_cycle <= '{1'h1, k[2], k[1], k[0], sz, a, f[2]};
    cpu_ctx <= '{f[1], NPC, LPC};
    mask_level <= 4'hF;
    delay <= seed[3:0];
    @(posedge sys_clk);
    bus_cycle.valid <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk("BREAK_REQ", {31'h0, req}, {31'h0, f[0]});
    chk("IRQ", {31'h0, irq}, {31'h0, f[0]});
    if (f[0]) chk("SAVED_PC", saved_pc, pc);
    rd(break_unit_pkg::OFS_STATUS, {15'h0, f[0]});
    if (f[0]) rd(break_unit_pkg::OFS_SAVED_PC, pc[15:0]);
    mask_level <= 4'hE;
    for (int i = 0; i < 24 && req === 1'h1; i++) @(posedge sys_clk);
    #1;
    chk("BREAK_REQ", {31'h0, req}, 32'h0);
    rd(break_unit_pkg::OFS_STATUS, {14'h0, f[0], f[0]});
    wr(break_unit_pkg::OFS_STATUS, 16'h0003);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("IRQ", {31'h0, irq}, 32'h0);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    rd(break_unit_pkg::OFS_COND, 16'h0000);
    wr(break_unit_pkg::OFS_COND, 16'h00FF);
    rd(break_unit_pkg::OFS_COND, 16'h00FF);
    wr(break_unit_pkg::OFS_ADDR_HI, CMP[31:16]);
    wr(break_unit_pkg::OFS_ADDR_LO, CMP[15:0]);
    wr(break_unit_pkg::OFS_MASK_HI, MSK[31:16]);
    wr(break_unit_pkg::OFS_MASK_LO, MSK[15:0]);
    wr(break_unit_pkg::OFS_IRQ_MASK, 16'h0001);
    try(16'h0054, 3'h2, 2'h2, 32'h0, 3'h1);
    try(16'h0058, 3'h2, 2'h2, 32'h0, 3'h0);
    try(16'h006A, 3'h1, 2'h2, 32'h0, 3'h1);
    try(16'h0069, 3'h1, 2'h1, 32'h0, 3'h1);
    try(16'h0066, 3'h0, 2'h1, 32'h0, 3'h0);
    try(16'h00A7, 3'h4, 2'h3, 32'h0, 3'h1);
    try(16'h0067, 3'h4, 2'h3, 32'h0, 3'h0);
    try(16'h00A7, 3'h0, 2'h3, 32'h0, 3'h0);
    try(16'h0064, 3'h2, 2'h2, 32'h0, 3'h0);
    try(16'h0054, 3'h0, 2'h2, 32'h0, 3'h0);
    try(16'h0065, 3'h1, 2'h1, 32'h0, 3'h0);
    try(16'h00FC, 3'h5, 2'h1, 32'h0, 3'h1);
    try(16'h00DC, 3'h2, 2'h1, 32'h0, 3'h3);
    try(16'h0056, 3'h2, 2'h1, 32'h0, 3'h1);
    try(16'h0067, 3'h0, 2'h3, 32'h0, 3'h1);
    try(16'h0054, 3'h2, 2'h2, 32'h2, 3'h5);
    try(16'h0054, 3'h2, 2'h2, 32'h0001_0000, 3'h0);
    try(16'h0054, 3'h2, 2'h2, 32'h0000_0001, 3'h0);
    try(16'h0014, 3'h2, 2'h2, 32'h0, 3'h0);
    try(16'h0044, 3'h2, 2'h2, 32'h0, 3'h0);
    try(16'h0050, 3'h2, 2'h2, 32'h0, 3'h0);
    rd(break_unit_pkg::OFS_COND, 16'h0050);
    @(posedge sys_clk);
    hw_standby <= 1'h1;
    @(posedge sys_clk);
    hw_standby <= 1'h0;
    rd(break_unit_pkg::OFS_COND, 16'h0000);
    repeat (2) @(posedge sys_clk);
    conclude();
  end
  // A hang is cut short well past the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule // tb_break_unit
